// >>> sim/bcp_host_model.sv
// Host side model: register requests of the serial engine, and bus current.
// Assumes requests launch at a falling edge and are taken at the next rise.
`timescale 1ns/1ps
module bcp_host_model
(
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output bcp_pkg::bcp_req_type req,
  output logic [13:0] ibus_ma
);
  initial
  begin
    req = '0;
    ibus_ma = 14'h0000; // Adapter kept under trip unless a test says
  end
  // One access per call; read data valid from the taking edge, sampled at the next fall
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
    output logic [7:0] rdata);
    @(negedge clk);
    req <= {wr, !wr, addr, wdata};
    @(negedge clk);
    req <= '0;
    rdata = rd_data;
  endtask
endmodule

// >>> sim/bcp_regs_props.sv
// Checker for the bus current protection registers, bound into bcp_regs.
// Assumes inputs change only between rising edges and stay quiet in reset.
`timescale 1ns/1ps
module bcp_regs_chk
#(
  parameter int SS_CYCLES = bcp_pkg::BCP_SS_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire bcp_pkg::bcp_req_type req,
  input wire bcp_pkg::bcp_sense_type sense,
  input wire logic [13:0] ibus_ma,
  input wire logic [7:0] rd_data,
  input wire logic int_pulse,
  input wire logic output_disable,
  input wire logic switching_active_status,
  input wire logic [13:0] trip_threshold_ma,
  input wire logic [13:0] alarm_threshold_ma
);
  localparam int SS_LIM = SS_CYCLES + 3;
  logic trip_dis_r, trip_dis_nxt, mask_r, mask_nxt, wr_prot, wr_alm, regrst;
  logic [15:0] ss_cnt_r, ss_cnt_nxt;
  assign wr_prot = req.wr && req.addr == bcp_pkg::BCP_ADDR_PROTECT;
  assign wr_alm = req.wr && req.addr == bcp_pkg::BCP_ADDR_ALARM;
  assign regrst = req.wr && req.addr == bcp_pkg::BCP_ADDR_CONTROL && req.wdata[7];
  // Shadow of the trip disable and rise mask bits, since the checker sees no register
  always_comb
  begin
    trip_dis_nxt = regrst ? 1'b0 : (wr_prot ? req.wdata[7] : trip_dis_r);
    mask_nxt = regrst ? 1'b0 : (wr_prot ? req.wdata[5] : mask_r);
    ss_cnt_nxt = (switching_active_status && !sense.ucp_above) ? ss_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trip_dis_r <= 1'b0;
      mask_r <= 1'b0;
      ss_cnt_r <= 16'h0000;
    end
    else
    begin
      trip_dis_r <= trip_dis_nxt;
      mask_r <= mask_nxt;
      ss_cnt_r <= ss_cnt_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_trip;
    output_disable == $past(ibus_ma >= trip_threshold_ma && !trip_dis_r);
  endproperty
  property p_trip_thr;
    $past(wr_prot, 2) |->
      trip_threshold_ma == 14'h03E8 + 14'h00FA * {10'h000, $past(req.wdata[3:0], 2)};
  endproperty
  property p_alm_thr;
    $past(wr_alm, 2) |-> alarm_threshold_ma == (($past(req.wdata[6:0], 2) == 7'h00) ? 14'h0000 :
      14'h0032 * {7'h00, $past(req.wdata[6:0], 2)} - 14'h0032);
  endproperty
  property p_ctl_rd;
    $past(req.rd && req.addr == bcp_pkg::BCP_ADDR_CONTROL) |-> rd_data == 8'h00;
  endproperty
  property p_evt_int;
    $past(sense.tshut_event || sense.conv_ocp_event || sense.flycap_event || sense.switch_start)
      |-> int_pulse;
  endproperty
  property p_fall_int;
    $past(sense.ucp_above, 2) && !$past(sense.ucp_above) |-> int_pulse;
  endproperty
  property p_rise_int;
    !$past(sense.ucp_above, 2) && $past(sense.ucp_above) && !$past(mask_r) |-> int_pulse;
  endproperty
  property p_ss_limit;
    ss_cnt_r <= SS_LIM;
  endproperty
  a_trip: assert property (p_trip) else $error("trip output wrong");
  a_trip_thr: assert property (p_trip_thr) else $error("trip threshold wrong");
  a_alm_thr: assert property (p_alm_thr) else $error("alarm threshold wrong");
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read not zero");
  a_evt_int: assert property (p_evt_int) else $error("event without interrupt");
  a_fall_int: assert property (p_fall_int) else $error("fall without interrupt");
  a_rise_int: assert property (p_rise_int) else $error("rise without interrupt");
  a_ss_limit: assert property (p_ss_limit) else $error("soft start overran");
  c_trip: cover property (output_disable);
  c_ss_stop: cover property ($fell(switching_active_status));
  c_rise: cover property ($rose(sense.ucp_above));
endmodule

bind bcp_regs bcp_regs_chk #(.SS_CYCLES(SS_CYCLES)) u_chk (.clk, .nrst, .req, .sense, .ibus_ma,
  .rd_data, .int_pulse, .output_disable, .switching_active_status, .trip_threshold_ma,
  .alarm_threshold_ma);

// >>> sim/bcp_regs_tb.sv
// Testbench for bcp_regs: table of register cases, then hand-written cases.
// Assumes the host model drives requests and current at falling edges.
`timescale 1ns/1ps
module bcp_regs_tb;
  localparam int SS = 20;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} bcp_row_type;
  logic clk, nrst, int_pulse, output_disable, switching_active_status;
  bcp_pkg::bcp_sense_type sense;
  bcp_pkg::bcp_req_type req;
  logic [13:0] ibus_ma, trip_threshold_ma, alarm_threshold_ma;
  logic [7:0] rd_data, rdat;
  int n_errors = 0, total_checks = 0, n_int;
  bcp_row_type rows[8] = '{'{8'h08, 8'hFF, 8'hAF}, '{8'h08, 8'h00, 8'h00},
    '{8'h09, 8'hFF, 8'hFF}, '{8'h09, 8'h00, 8'h00}, '{8'h0A, 8'hFF, 8'h00},
    '{8'h0C, 8'hFF, 8'h00}, '{8'h0B, 8'h80, 8'h00}, '{8'h09, 8'h81, 8'h81}};
  bcp_host_model host (.clk, .rd_data, .req, .ibus_ma);
  bcp_regs #(.SS_CYCLES(SS)) DUT (.clk, .nrst, .req, .sense, .ibus_ma, .rd_data, .int_pulse,
    .output_disable, .switching_active_status, .trip_threshold_ma, .alarm_threshold_ma);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, rdat);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, rdat);
    check("read data", 16'(rdat), 16'(e));
  endtask
  task automatic count_int(input int n);
    n_int = 0;
    repeat (n) @(negedge clk) n_int += int'(int_pulse === 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is well under 1000 cycles; twenty times that is a hang
  initial
  begin
    #80000;
    n_errors++;
    conclude();
  end
  initial
  begin
    nrst = 1'b0;
    sense = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check("trip threshold", 16'(trip_threshold_ma), 16'h109A);
    // Default code 1010000 through the formula: 80 * 50 mA - 50 mA
    check("alarm threshold", 16'(alarm_threshold_ma), 16'h0F6E);
    nrst = 1'b1;
    rdchk(8'h08, 8'h0D);
    rdchk(8'h09, 8'h50);
    sense.ucp_above = 1'b1;
    count_int(3);
    check("rise interrupt", 16'(n_int), 16'h0001);
    rdchk(8'h08, 8'h4D);
    rdchk(8'h08, 8'h0D);
    sense.ucp_above = 1'b0;
    count_int(3);
    check("fall interrupt", 16'(n_int), 16'h0001);
    rdchk(8'h08, 8'h1D);
    wr(8'h08, 8'h2D);
    // Rise lands on the edge that takes the read: flag must survive it
    fork
      rdchk(8'h08, 8'h2D);
      begin
        @(negedge clk);
        sense.ucp_above = 1'b1;
        count_int(3);
      end
    join
    check("masked interrupt", 16'(n_int), 16'h0000);
    rdchk(8'h08, 8'h6D);
    sense.ucp_above = 1'b0;
    wr(8'h08, 8'h0D);
    host.ibus_ma = 14'h109A;
    repeat (2) @(negedge clk);
    check("trip at threshold", 16'(output_disable), 16'h0001);
    host.ibus_ma = 14'h1099;
    repeat (2) @(negedge clk);
    check("trip below threshold", 16'(output_disable), 16'h0000);
    host.ibus_ma = 14'h109A;
    wr(8'h08, 8'h8D);
    repeat (2) @(negedge clk);
    check("trip disabled", 16'(output_disable), 16'h0000);
    host.ibus_ma = 14'h0000;
    wr(8'h08, 8'h0D);
    host.ibus_ma = 14'h0FA0;
    count_int(3);
    check("alarm interrupt", 16'(n_int), 16'h0001);
    host.ibus_ma = 14'h0000;
    wr(8'h09, 8'hD0);
    host.ibus_ma = 14'h0FA0;
    count_int(3);
    check("alarm disabled", 16'(n_int), 16'h0000);
    host.ibus_ma = 14'h0000;
    sense = 8'hFC;
    @(negedge clk);
    sense = 8'h70;
    rdchk(8'h0A, 8'hF3);
    rdchk(8'h0A, 8'h70);
    sense = 8'h8C;
    @(negedge clk);
    sense = 8'h00;
    wr(8'h08, 8'h2F);
    wr(8'h0B, 8'h80);
    rdchk(8'h0A, 8'h02);
    rdchk(8'h08, 8'h0D);
    rdchk(8'h09, 8'h50);
    sense.switch_start = 1'b1;
    @(negedge clk);
    sense.switch_start = 1'b0;
    repeat (SS - 1) @(negedge clk);
    check("ramp running", 16'(switching_active_status), 16'h0001);
    @(negedge clk);
    check("ramp timed out", 16'(switching_active_status), 16'h0000);
    rdchk(8'h0A, 8'h08);
    sense.switch_start = 1'b1;
    @(negedge clk);
    sense = 8'h01;
    repeat (30) @(negedge clk);
    check("run holds", 16'(switching_active_status), 16'h0001);
    sense = 8'h41;
    repeat (3) @(negedge clk);
    check("thermal stop", 16'(switching_active_status), 16'h0000);
    sense = 8'h00;
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule

// >>> src/bcp_pkg.sv
// Package for the bus current protection register bank.
// Assumes an 8-bit register port driven by the serial interface engine.
package bcp_pkg;

  // Register offsets
  localparam logic [7:0] BCP_ADDR_PROTECT = 8'h08;
  localparam logic [7:0] BCP_ADDR_ALARM = 8'h09;
  localparam logic [7:0] BCP_ADDR_STATE = 8'h0A;
  localparam logic [7:0] BCP_ADDR_CONTROL = 8'h0B;

  // Reset values
  localparam logic [7:0] BCP_RST_PROTECT = 8'h0D;
  localparam logic [7:0] BCP_RST_ALARM = 8'h50;
  localparam logic [7:0] BCP_RST_STATE = 8'h00;
  localparam logic [7:0] BCP_RD_ZERO = 8'h00;

  // Protect register fields
  localparam int BCP_OCP_DIS_BIT = 7;
  localparam int BCP_RISE_FLAG_BIT = 6;
  localparam int BCP_RISE_MASK_BIT = 5;
  localparam int BCP_FALL_FLAG_BIT = 4;
  localparam int BCP_OCP_CODE_W = 4;

  // Alarm register fields
  localparam int BCP_ALM_DIS_BIT = 7;
  localparam int BCP_ALM_CODE_W = 7;

  // Control register fields
  localparam int BCP_REG_RST_BIT = 7;

  // Converter state bit positions
  localparam int BCP_ST_THERMAL_SHUTDOWN_FLAG = 7;
  localparam int BCP_ST_THERMAL_SHUTDOWN_STATUS = 6;
  localparam int BCP_ST_BUS_LOW = 5;
  localparam int BCP_ST_BUS_HIGH = 4;
  localparam int BCP_ST_SS_TIMEOUT = 3;
  localparam int BCP_ST_SWITCHING = 2;
  localparam int BCP_ST_CONV_OCP = 1;
  localparam int BCP_ST_FLYCAP = 0;

  // Current scaling, milliamps
  localparam int BCP_CUR_W = 14;
  localparam logic [13:0] BCP_OCP_OFFSET_MA = 14'h03E8;
  localparam logic [13:0] BCP_OCP_STEP_MA = 14'h00FA;
  localparam logic [13:0] BCP_ALM_STEP_MA = 14'h0032;
  localparam logic [13:0] BCP_ZERO_MA = 14'h0000;

  // Read-to-clear flag slots
  localparam int BCP_FL_RISE = 0;
  localparam int BCP_FL_FALL = 1;
  localparam int BCP_FL_TSHUT = 2;
  localparam int BCP_FL_SS_TO = 3;
  localparam int BCP_FL_CONV_OCP = 4;
  localparam int BCP_FL_FLYCAP = 5;
  localparam int BCP_NFLAGS = 6;
  // Flags that a register reset clears
  localparam logic [5:0] BCP_FL_REGRST = 6'h27;

  // Default soft-start window in cycles
  localparam int BCP_SS_CYCLES_DEF = 1000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcp_req_type;

  typedef struct packed {
    logic tshut_event;
    logic tshut_active;
    logic bus_low;
    logic bus_high;
    logic conv_ocp_event;
    logic flycap_event;
    logic switch_start;
    logic ucp_above;
  } bcp_sense_type;

endpackage

// >>> src/bcp_rc_flag.sv
// Read-to-clear event flag.
// Assumes set, read clear and register reset clear are one-cycle strobes.
`timescale 1ns/1ps
module bcp_rc_flag
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic rd_clr,
  input wire logic rst_clr,
  output logic flag
);

  logic flag_r;
  logic flag_nxt;

  // Set wins so an event during the read survives
  always_comb
  begin
    flag_nxt = set | (flag_r & ~rd_clr & ~rst_clr);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;

endmodule

// >>> src/bcp_regs.sv
// Bus current protection registers: trip, alarm, undercurrent flags,
// converter state. Assumes the serial engine gives one-cycle wr/rd strobes
// and a measured bus current in milliamps, all synchronous to clk.
`timescale 1ns/1ps

module bcp_regs
#(
  parameter int SS_CYCLES = bcp_pkg::BCP_SS_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire bcp_pkg::bcp_req_type req,
  input wire bcp_pkg::bcp_sense_type sense,
  input wire logic [13:0] ibus_ma,
  output logic [7:0] rd_data,
  output logic int_pulse,
  output logic output_disable,
  output logic switching_active_status,
  output logic [13:0] trip_threshold_ma,
  output logic [13:0] alarm_threshold_ma
);

  // Writable fields
  logic overcurrent_trip_disable_r, overcurrent_trip_disable_nxt;
  logic undercurrent_rise_mask_r, undercurrent_rise_mask_nxt;
  logic [3:0] overcurrent_trip_threshold_r, overcurrent_trip_threshold_nxt;
  logic overcurrent_alarm_disable_r, overcurrent_alarm_disable_nxt;
  logic [6:0] overcurrent_alarm_threshold_r, overcurrent_alarm_threshold_nxt;

  // Derived and status state
  logic [7:0] rd_data_r, rd_data_nxt;
  logic int_r, int_nxt;
  logic out_dis_r, out_dis_nxt;
  logic ucp_prev_r, ucp_prev_nxt;
  logic alm_prev_r, alm_prev_nxt;
  logic [13:0] trip_thr_r, trip_thr_nxt;
  logic [13:0] alm_thr_r, alm_thr_nxt;

  logic reg_rst;
  logic rd_protect;
  logic rd_state;
  logic rise_evt;
  logic fall_evt;
  logic alm_hit;
  logic trip_hit;
  logic ss_timeout;
  logic switching;
  logic [bcp_pkg::BCP_NFLAGS-1:0] flag_set;
  logic [bcp_pkg::BCP_NFLAGS-1:0] flag_rd;
  logic [bcp_pkg::BCP_NFLAGS-1:0] flags;
  logic [7:0] protect_val;
  logic [7:0] alarm_val;
  logic [7:0] state_val;

  // Register reset strobe; the bit itself is never stored
  assign reg_rst = req.wr && (req.addr == bcp_pkg::BCP_ADDR_CONTROL)
                   && req.wdata[bcp_pkg::BCP_REG_RST_BIT];
  assign rd_protect = req.rd && (req.addr == bcp_pkg::BCP_ADDR_PROTECT);
  assign rd_state = req.rd && (req.addr == bcp_pkg::BCP_ADDR_STATE);

  // Edges of the undercurrent comparator
  assign rise_evt = sense.ucp_above & ~ucp_prev_r;
  assign fall_evt = ~sense.ucp_above & ucp_prev_r;

  // Thresholds compared against the measured current
  assign trip_hit = (ibus_ma >= trip_thr_r);
  assign alm_hit = (ibus_ma >= alm_thr_r);

  // Event sources and which read clears them
  always_comb
  begin
    flag_set = '0;
    flag_rd = '0;
    flag_set[bcp_pkg::BCP_FL_RISE] = rise_evt;
    flag_set[bcp_pkg::BCP_FL_FALL] = fall_evt;
    flag_set[bcp_pkg::BCP_FL_TSHUT] = sense.tshut_event;
    flag_set[bcp_pkg::BCP_FL_SS_TO] = ss_timeout;
    flag_set[bcp_pkg::BCP_FL_CONV_OCP] = sense.conv_ocp_event;
    flag_set[bcp_pkg::BCP_FL_FLYCAP] = sense.flycap_event;
    flag_rd[bcp_pkg::BCP_FL_RISE] = rd_protect;
    flag_rd[bcp_pkg::BCP_FL_FALL] = rd_protect;
    flag_rd[bcp_pkg::BCP_FL_TSHUT] = rd_state;
    flag_rd[bcp_pkg::BCP_FL_SS_TO] = rd_state;
    flag_rd[bcp_pkg::BCP_FL_CONV_OCP] = rd_state;
    flag_rd[bcp_pkg::BCP_FL_FLYCAP] = rd_state;
  end

  // One read-to-clear cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < bcp_pkg::BCP_NFLAGS; gi++)
    begin : g_flag
      bcp_rc_flag u_flag
      (
        .clk(clk),
        .nrst(nrst),
        .set(flag_set[gi]),
        .rd_clr(flag_rd[gi]),
        .rst_clr(reg_rst & bcp_pkg::BCP_FL_REGRST[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // Switching stops on thermal shutdown or a trip
  bcp_ss_timer #(.SS_CYCLES(SS_CYCLES)) u_ss
  (
    .clk(clk),
    .nrst(nrst),
    .start(sense.switch_start),
    .stop(sense.tshut_active | out_dis_r),
    .ucp_above(sense.ucp_above),
    .switching(switching),
    .timeout(ss_timeout)
  );

  // Readback images
  always_comb
  begin
    protect_val = {overcurrent_trip_disable_r, flags[bcp_pkg::BCP_FL_RISE],
                   undercurrent_rise_mask_r, flags[bcp_pkg::BCP_FL_FALL],
                   overcurrent_trip_threshold_r};
    alarm_val = {overcurrent_alarm_disable_r, overcurrent_alarm_threshold_r};
    state_val = bcp_pkg::BCP_RST_STATE;
    state_val[bcp_pkg::BCP_ST_THERMAL_SHUTDOWN_FLAG] = flags[bcp_pkg::BCP_FL_TSHUT];
    state_val[bcp_pkg::BCP_ST_THERMAL_SHUTDOWN_STATUS] = sense.tshut_active;
    state_val[bcp_pkg::BCP_ST_BUS_LOW] = sense.bus_low;
    state_val[bcp_pkg::BCP_ST_BUS_HIGH] = sense.bus_high;
    state_val[bcp_pkg::BCP_ST_SS_TIMEOUT] = flags[bcp_pkg::BCP_FL_SS_TO];
    state_val[bcp_pkg::BCP_ST_SWITCHING] = switching;
    state_val[bcp_pkg::BCP_ST_CONV_OCP] = flags[bcp_pkg::BCP_FL_CONV_OCP];
    state_val[bcp_pkg::BCP_ST_FLYCAP] = flags[bcp_pkg::BCP_FL_FLYCAP];
  end

  // Writable fields; no watchdog input reaches them
  always_comb
  begin
    overcurrent_trip_disable_nxt = overcurrent_trip_disable_r;
    undercurrent_rise_mask_nxt = undercurrent_rise_mask_r;
    overcurrent_trip_threshold_nxt = overcurrent_trip_threshold_r;
    overcurrent_alarm_disable_nxt = overcurrent_alarm_disable_r;
    overcurrent_alarm_threshold_nxt = overcurrent_alarm_threshold_r;
    if (reg_rst)
    begin
      // Defaults from the reset images
      overcurrent_trip_disable_nxt = bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_OCP_DIS_BIT];
      undercurrent_rise_mask_nxt = bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_RISE_MASK_BIT];
      overcurrent_trip_threshold_nxt = bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_OCP_CODE_W-1:0];
      overcurrent_alarm_disable_nxt = bcp_pkg::BCP_RST_ALARM[bcp_pkg::BCP_ALM_DIS_BIT];
      overcurrent_alarm_threshold_nxt = bcp_pkg::BCP_RST_ALARM[bcp_pkg::BCP_ALM_CODE_W-1:0];
    end
    else if (req.wr && req.addr == bcp_pkg::BCP_ADDR_PROTECT)
    begin
      // Flag bits are read-only and ignore written data
      overcurrent_trip_disable_nxt = req.wdata[bcp_pkg::BCP_OCP_DIS_BIT];
      undercurrent_rise_mask_nxt = req.wdata[bcp_pkg::BCP_RISE_MASK_BIT];
      overcurrent_trip_threshold_nxt = req.wdata[bcp_pkg::BCP_OCP_CODE_W-1:0];
    end
    else if (req.wr && req.addr == bcp_pkg::BCP_ADDR_ALARM)
    begin
      overcurrent_alarm_disable_nxt = req.wdata[bcp_pkg::BCP_ALM_DIS_BIT];
      overcurrent_alarm_threshold_nxt = req.wdata[bcp_pkg::BCP_ALM_CODE_W-1:0];
    end
  end

  // Thresholds
  always_comb
  begin
    // Threshold follows the stored code one cycle later
    trip_thr_nxt = bcp_pkg::BCP_OCP_OFFSET_MA
                   + 14'(overcurrent_trip_threshold_r) * bcp_pkg::BCP_OCP_STEP_MA;
    // All-zero code means 0 A, not a negative value
    if (overcurrent_alarm_threshold_r == '0)
      alm_thr_nxt = bcp_pkg::BCP_ZERO_MA;
    else
      alm_thr_nxt = 14'(overcurrent_alarm_threshold_r) * bcp_pkg::BCP_ALM_STEP_MA
                    - bcp_pkg::BCP_ALM_STEP_MA;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Reset codes run through the same formulas, so no step after release
      trip_thr_r <= bcp_pkg::BCP_OCP_OFFSET_MA
                    + 14'(bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_OCP_CODE_W-1:0])
                    * bcp_pkg::BCP_OCP_STEP_MA;
      alm_thr_r <= 14'(bcp_pkg::BCP_RST_ALARM[bcp_pkg::BCP_ALM_CODE_W-1:0])
                   * bcp_pkg::BCP_ALM_STEP_MA - bcp_pkg::BCP_ALM_STEP_MA;
    end
    else
    begin
      trip_thr_r <= trip_thr_nxt;
      alm_thr_r <= alm_thr_nxt;
    end
  end

  // Trip, edge history and interrupt
  always_comb
  begin
    // Level trip; released once current falls back
    out_dis_nxt = trip_hit & ~overcurrent_trip_disable_r;
    ucp_prev_nxt = sense.ucp_above;
    alm_prev_nxt = alm_hit;
    // One pulse per event, so a held alarm does not repeat
    int_nxt = (rise_evt & ~undercurrent_rise_mask_r)
              | fall_evt
              | (alm_hit & ~alm_prev_r & ~overcurrent_alarm_disable_r)
              | sense.tshut_event
              | ss_timeout
              | sense.conv_ocp_event
              | sense.flycap_event
              | sense.switch_start;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_dis_r <= 1'b0;
      ucp_prev_r <= 1'b0;
      alm_prev_r <= 1'b0;
      int_r <= 1'b0;
    end
    else
    begin
      out_dis_r <= out_dis_nxt;
      ucp_prev_r <= ucp_prev_nxt;
      alm_prev_r <= alm_prev_nxt;
      int_r <= int_nxt;
    end
  end

  // Read data captured with the flags before they clear
  always_comb
  begin
    rd_data_nxt = rd_data_r;
    if (req.rd)
    begin
      case (req.addr)
        bcp_pkg::BCP_ADDR_PROTECT: rd_data_nxt = protect_val;
        bcp_pkg::BCP_ADDR_ALARM: rd_data_nxt = alarm_val;
        bcp_pkg::BCP_ADDR_STATE: rd_data_nxt = state_val;
        bcp_pkg::BCP_ADDR_CONTROL: rd_data_nxt = bcp_pkg::BCP_RD_ZERO;
        default: rd_data_nxt = bcp_pkg::BCP_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overcurrent_trip_disable_r <= bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_OCP_DIS_BIT];
      undercurrent_rise_mask_r <= bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_RISE_MASK_BIT];
      overcurrent_trip_threshold_r <= bcp_pkg::BCP_RST_PROTECT[bcp_pkg::BCP_OCP_CODE_W-1:0];
      overcurrent_alarm_disable_r <= bcp_pkg::BCP_RST_ALARM[bcp_pkg::BCP_ALM_DIS_BIT];
      overcurrent_alarm_threshold_r <= bcp_pkg::BCP_RST_ALARM[bcp_pkg::BCP_ALM_CODE_W-1:0];
    end
    else
    begin
      overcurrent_trip_disable_r <= overcurrent_trip_disable_nxt;
      undercurrent_rise_mask_r <= undercurrent_rise_mask_nxt;
      overcurrent_trip_threshold_r <= overcurrent_trip_threshold_nxt;
      overcurrent_alarm_disable_r <= overcurrent_alarm_disable_nxt;
      overcurrent_alarm_threshold_r <= overcurrent_alarm_threshold_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_r <= bcp_pkg::BCP_RD_ZERO;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign int_pulse = int_r;
  assign output_disable = out_dis_r;
  assign switching_active_status = switching;
  assign trip_threshold_ma = trip_thr_r;
  assign alarm_threshold_ma = alm_thr_r;

endmodule

// >>> src/bcp_ss_timer.sv
// Soft-start window timer for the converter.
// Assumes start is a one-cycle strobe and ucp_above a synchronous level.
`timescale 1ns/1ps
module bcp_ss_timer
#(
  parameter int SS_CYCLES = bcp_pkg::BCP_SS_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  input wire logic ucp_above,
  output logic switching,
  output logic timeout
);

  typedef enum logic [1:0] {BCP_SS_IDLE, BCP_SS_RAMP, BCP_SS_RUN} bcp_ss_state_type;

  localparam int CW = $clog2(SS_CYCLES + 1);

  bcp_ss_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic timeout_r, timeout_nxt;
  logic switching_r, switching_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    timeout_nxt = 1'b0;
    case (state_r)
      BCP_SS_IDLE:
      begin
        if (start && !stop)
        begin
          state_nxt = BCP_SS_RAMP;
          cnt_nxt = '0;
        end
      end
      BCP_SS_RAMP:
      begin
        if (stop)
          state_nxt = BCP_SS_IDLE;
        else if (ucp_above)
          state_nxt = BCP_SS_RUN;
        else if (cnt_r == CW'(SS_CYCLES - 1))
        begin
          // Current never ramped; stop switching
          state_nxt = BCP_SS_IDLE;
          timeout_nxt = 1'b1;
        end
        else
          cnt_nxt = cnt_r + CW'(1);
      end
      BCP_SS_RUN:
      begin
        if (stop)
          state_nxt = BCP_SS_IDLE;
      end
      default:
        state_nxt = BCP_SS_IDLE;
    endcase
    // Registered so the status output comes straight from a flop
    switching_nxt = (state_nxt != BCP_SS_IDLE);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= BCP_SS_IDLE;
      cnt_r <= '0;
      timeout_r <= 1'b0;
      switching_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
      switching_r <= switching_nxt;
    end
  end

  assign switching = switching_r;
  assign timeout = timeout_r;

endmodule
